// File: hdl/spa_pkg.sv
// Purpose: constants and types for the sensor position auto-clear block
// Assumes: 100 MHz clk_i, classic Wishbone register access
// Notes: all counts of milliseconds run off one shared millisecond tick
package spa_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned CLEAR_MAX_MS = 1;
    localparam logic [7:0] FOLLOW_TIMEOUT_MS = 8'h64;
    localparam logic [7:0] REPORT_MS = 8'h14;
    localparam logic [7:0] RAW_RATE_RESET = 8'h64;
    localparam logic [7:0] RED_FLASH_MS = 8'h32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POS = 8'h04;
    localparam logic [7:0] OFS_VEL = 8'h08;
    localparam logic [7:0] OFS_FAULT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RAW_RATE = 8'h14;
    localparam logic [7:0] OFS_RAW_ENC = 8'h18;
    localparam logic [7:0] OFS_RAW_ANA = 8'h1c;
    localparam logic [7:0] OFS_DEV_ID = 8'h20;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_IDX_EN = 0;
    localparam int unsigned CTRL_FWD_EN = 1;
    localparam int unsigned CTRL_REV_EN = 2;
    localparam int unsigned CTRL_SEL_ANA = 3;
    localparam int unsigned CTRL_PHASE = 4;
    localparam int unsigned CTRL_FOLLOW = 5;
    localparam int unsigned CTRL_OVR_VALID = 6;
    localparam int unsigned CTRL_OVR_BRAKE = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] DEV_ID_RESET = 6'h01;
    localparam logic [5:0] DEV_ID_MAX = 6'h3f;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } spa_wb_req_t;

    typedef enum logic [1:0] {
        SPA_LED_OFF,
        SPA_LED_BLINK_ORANGE,
        SPA_LED_SOLID_ORANGE,
        SPA_LED_RED
    } spa_led_t;

    typedef enum logic [1:0] {
        SPA_FOL_IDLE,
        SPA_FOL_OK,
        SPA_FOL_TIMEOUT
    } spa_fol_t;

endpackage

// File: hdl/spa_autoclear.sv
// Purpose: position auto-clear, follower timeout, fault log, brake, reporting
// Assumes: all pins synchronous to clk_i except index and limits (synchronised)
// Notes:
// Notes on behaviour
// - index clear enabled: each index rising edge zeroes the selected position.
// - limit clear enabled: position held at zero while that limit is closed.
// - clear happens locally, well under one millisecond after the event.
// - clearing works even when the drive is disabled.
// - clearing works whichever sensor is selected.
// - three separate clear enables, 1 on and 0 off.
// - index pin pulled up; open-drain or 3.3V sources both work.
// - follower disables drive after 100 ms without master update.
// - after follower timeout show enabled with zero output, solid orange.
// - sticky faults are a log only and never affect drive.
// - live and sticky faults readable; clear command wipes sticky flags.
// - button toggles stored brake mode; bus override wins for neutral (brake_o) only; led does not show brake mode.
// - any CAN error frame flashes the led red briefly.
// - selected sensor feeds position and velocity, reported every 20 ms.
// - raw encoder and analog reported every 100 ms by default, faster if set.
// - phase setting signs the selected position and velocity.
// - device ids come from 63 values and must be unique.
// - both sides talk over a 1 Mbps two-wire CAN bus.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module spa_autoclear
    import spa_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire spa_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic index_drive_i,
    input wire logic index_level_i,
    input wire logic fwd_limit_closed_i,
    input wire logic rev_limit_closed_i,
    input wire logic enc_step_i,
    input wire logic enc_dir_i,
    input wire logic [9:0] analog_i,
    input wire logic [7:0] fault_i,
    input wire logic robot_enable_i,
    input wire logic master_update_i,
    input wire logic can_error_frame_i,
    input wire logic cal_button_i,
    output logic drive_enable_o,
    output logic brake_o,
    output spa_led_t led_o,
    output logic report_strobe_o,
    output logic raw_strobe_o
);

    function automatic logic [31:0] apply_phase(input logic inv, input logic [31:0] v);
        apply_phase = inv ? 32'(-v) : v;
    endfunction

    // ------------------------------------------------------------
    // pins and synchronisers
    // ------------------------------------------------------------
    // undriven index floats high through the internal pull-up
    wire idx_pin_lvl = index_drive_i ? index_level_i : 1'b1;
    logic [2:0] idx_sync_reg;
    logic [1:0] fwd_sync_reg;
    logic [1:0] rev_sync_reg;
    logic cal_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_sync_reg <= 3'h7;
            fwd_sync_reg <= 2'h0;
            rev_sync_reg <= 2'h0;
            cal_prev_reg <= 1'b0;
        end else if (ce_i) begin
            idx_sync_reg <= {idx_sync_reg[1:0], idx_pin_lvl};
            fwd_sync_reg <= {fwd_sync_reg[0], fwd_limit_closed_i};
            rev_sync_reg <= {rev_sync_reg[0], rev_limit_closed_i};
            cal_prev_reg <= cal_button_i;
        end
    end

    // edge taken from stages two and three only, so one edge gives one clear
    wire idx_rise = idx_sync_reg[1] & ~idx_sync_reg[2];
    wire cal_press = cal_button_i & ~cal_prev_reg;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] raw_rate_reg;
    logic [5:0] dev_id_reg;
    wire cfg_idx_en = ctrl_reg[CTRL_IDX_EN];
    wire cfg_fwd_en = ctrl_reg[CTRL_FWD_EN];
    wire cfg_rev_en = ctrl_reg[CTRL_REV_EN];
    wire cfg_sel_ana = ctrl_reg[CTRL_SEL_ANA];
    wire cfg_phase = ctrl_reg[CTRL_PHASE];
    wire cfg_follow = ctrl_reg[CTRL_FOLLOW];
    wire cfg_ovr_valid = ctrl_reg[CTRL_OVR_VALID];
    wire cfg_ovr_brake = ctrl_reg[CTRL_OVR_BRAKE];

    // clear is independent of drive enable and sensor choice
    wire clr_idx = cfg_idx_en & idx_rise;
    wire clr_lim = (cfg_fwd_en & fwd_sync_reg[1]) | (cfg_rev_en & rev_sync_reg[1]);
    wire clr_any = clr_idx | clr_lim;

    // ------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------
    wire wb_req = wb_i.cyc & wb_i.stb;
    wire wb_fire = wb_req & ~wb_ack_o;
    wire wb_wr = wb_req & wb_i.we & wb_ack_o & wb_i.sel[0];
    wire wr_ctrl = wb_wr & (wb_i.adr == OFS_CTRL);
    wire wr_fault = wb_wr & (wb_i.adr == OFS_FAULT);
    wire wr_rate = wb_wr & (wb_i.adr == OFS_RAW_RATE);
    wire wr_id = wb_wr & (wb_i.adr == OFS_DEV_ID);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            raw_rate_reg <= RAW_RATE_RESET;
            dev_id_reg <= DEV_ID_RESET;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_reg <= wb_i.dat[7:0];
            end
            // a zero period would wrap to a 256 ms report period; keep the old value
            if (wr_rate && wb_i.dat[7:0] != 8'h00) begin
                raw_rate_reg <= wb_i.dat[7:0];
            end
            // id zero is not one of the 63 usable ids
            if (wr_id && wb_i.dat[5:0] != 6'h00) begin
                dev_id_reg <= wb_i.dat[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sensors and position
    // ------------------------------------------------------------
    logic [31:0] quad_pos_reg;
    logic [9:0] ana_off_reg;
    wire [31:0] ana_pos = 32'({22'h0, analog_i}) - 32'({22'h0, ana_off_reg});
    wire [31:0] sel_raw = cfg_sel_ana ? ana_pos : quad_pos_reg;
    wire [31:0] sel_pos = apply_phase(cfg_phase, sel_raw);
    wire [31:0] quad_step = enc_dir_i ? 32'hffffffff : 32'h00000001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quad_pos_reg <= 32'h0;
            ana_off_reg <= 10'h0;
        end else if (ce_i) begin
            if (clr_any && !cfg_sel_ana) begin
                quad_pos_reg <= 32'h0;
            end else if (enc_step_i) begin
                quad_pos_reg <= quad_pos_reg + quad_step;
            end
            // an absolute sensor is zeroed by capturing its present value
            if (clr_any && cfg_sel_ana) begin
                ana_off_reg <= analog_i;
            end
        end
    end

    // ------------------------------------------------------------
    // millisecond tick and reporting
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_reg;
    wire ms_tick = (tick_cnt_reg == 32'(TICK_LEN - 1));
    logic [7:0] rep_ms_reg;
    logic [7:0] raw_ms_reg;
    logic [31:0] rep_pos_reg;
    logic [31:0] rep_vel_reg;
    logic [31:0] raw_enc_reg;
    logic [9:0] raw_ana_reg;
    wire rep_due = ms_tick & (rep_ms_reg == REPORT_MS - 8'h01);
    wire raw_due = ms_tick & (raw_ms_reg >= raw_rate_reg - 8'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 32'h0;
            rep_ms_reg <= 8'h0;
            raw_ms_reg <= 8'h0;
            rep_pos_reg <= 32'h0;
            rep_vel_reg <= 32'h0;
            raw_enc_reg <= 32'h0;
            raw_ana_reg <= 10'h0;
            report_strobe_o <= 1'b0;
            raw_strobe_o <= 1'b0;
        end else if (ce_i) begin
            tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
            report_strobe_o <= rep_due;
            raw_strobe_o <= raw_due;
            if (ms_tick) begin
                rep_ms_reg <= rep_due ? 8'h0 : rep_ms_reg + 8'h1;
                raw_ms_reg <= raw_due ? 8'h0 : raw_ms_reg + 8'h1;
            end
            if (rep_due) begin
                rep_pos_reg <= sel_pos;
                // velocity is the signed change per 20 ms window
                rep_vel_reg <= sel_pos - rep_pos_reg;
            end
            if (raw_due) begin
                raw_enc_reg <= quad_pos_reg;
                raw_ana_reg <= analog_i;
            end
        end
    end

    // ------------------------------------------------------------
    // follower watchdog
    // ------------------------------------------------------------
    spa_fol_t fol_reg;
    spa_fol_t fol_next;
    logic [7:0] fol_ms_reg;
    wire fol_expire = ms_tick & (fol_ms_reg == FOLLOW_TIMEOUT_MS - 8'h01) & ~master_update_i;

    always_comb begin
        fol_next = fol_reg;
        case (fol_reg)
            SPA_FOL_IDLE: begin
                if (cfg_follow) begin
                    fol_next = SPA_FOL_OK;
                end
            end
            SPA_FOL_OK: begin
                if (!cfg_follow) begin
                    fol_next = SPA_FOL_IDLE;
                end else if (fol_expire) begin
                    fol_next = SPA_FOL_TIMEOUT;
                end
            end
            SPA_FOL_TIMEOUT: begin
                if (!cfg_follow) begin
                    fol_next = SPA_FOL_IDLE;
                end else if (master_update_i) begin
                    fol_next = SPA_FOL_OK;
                end
            end
            default: fol_next = SPA_FOL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fol_reg <= SPA_FOL_IDLE;
            fol_ms_reg <= 8'h0;
        end else if (ce_i) begin
            fol_reg <= fol_next;
            if (master_update_i || fol_reg != SPA_FOL_OK) begin
                fol_ms_reg <= 8'h0;
            end else if (ms_tick) begin
                fol_ms_reg <= fol_ms_reg + 8'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // faults, brake, led, drive
    // ------------------------------------------------------------
    logic [7:0] sticky_reg;
    logic brake_mode_reg;
    logic [7:0] red_ms_reg;
    wire red_active = (red_ms_reg != 8'h00);
    // sticky flags never feed the drive path; they are only read back
    wire drive_ok = robot_enable_i & (fol_next != SPA_FOL_TIMEOUT);
    spa_led_t led_next;

    always_comb begin
        if (can_error_frame_i || red_active) begin
            led_next = SPA_LED_RED;
        end else if (!robot_enable_i) begin
            led_next = SPA_LED_BLINK_ORANGE;
        end else if (fol_next == SPA_FOL_TIMEOUT) begin
            led_next = SPA_LED_SOLID_ORANGE;
        end else begin
            led_next = SPA_LED_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_reg <= 8'h0;
            brake_mode_reg <= 1'b0;
            red_ms_reg <= 8'h0;
            drive_enable_o <= 1'b0;
            brake_o <= 1'b0;
            led_o <= SPA_LED_OFF;
        end else if (ce_i) begin
            // a fault present in the clear cycle survives the clear
            sticky_reg <= (wr_fault ? 8'h00 : sticky_reg) | fault_i;
            if (cal_press) begin
                brake_mode_reg <= ~brake_mode_reg;
            end
            if (can_error_frame_i) begin
                red_ms_reg <= RED_FLASH_MS;
            end else if (ms_tick && red_active) begin
                red_ms_reg <= red_ms_reg - 8'h01;
            end
            drive_enable_o <= drive_ok;
            brake_o <= cfg_ovr_valid ? cfg_ovr_brake : brake_mode_reg;
            led_o <= led_next;
        end
    end

    // ------------------------------------------------------------
    // wishbone read and ack
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (wb_i.adr)
            OFS_CTRL: rd_mux = {24'h0, ctrl_reg};
            OFS_POS: rd_mux = rep_pos_reg;
            OFS_VEL: rd_mux = rep_vel_reg;
            OFS_FAULT: rd_mux = {16'h0, sticky_reg, fault_i};
            OFS_STATUS: rd_mux = {24'h0, 1'b0, brake_o, fol_reg, led_o, drive_enable_o, red_active};
            OFS_RAW_RATE: rd_mux = {24'h0, raw_rate_reg};
            OFS_RAW_ENC: rd_mux = raw_enc_reg;
            OFS_RAW_ANA: rd_mux = {22'h0, raw_ana_reg};
            OFS_DEV_ID: rd_mux = {26'h0, dev_id_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= wb_fire;
            if (wb_fire) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_index_clears_pos: assert property (
        (ce_i && clr_idx && !cfg_sel_ana) |=> (quad_pos_reg == 32'h0))
        else $error("index edge did not clear position");
    a_limit_holds_zero: assert property (
        (ce_i && cfg_fwd_en && fwd_sync_reg[1] && !cfg_sel_ana) |=> (quad_pos_reg == 32'h0))
        else $error("closed limit did not hold position at zero");
    a_clear_latency: assert property (
        (ce_i && cfg_idx_en && !idx_sync_reg[0] && idx_pin_lvl) ##1 (ce_i && cfg_idx_en) |=> idx_rise)
        else $error("index edge not detected within two cycles");
    a_analog_clear: assert property (
        (ce_i && clr_any && cfg_sel_ana) |=> (ana_off_reg == $past(analog_i)))
        else $error("analog sensor not zeroed");
    a_single_clear: assert property (
        idx_rise && ce_i |=> !idx_rise)
        else $error("one index edge produced two clears");
    a_follow_timeout: assert property (
        (ce_i && fol_reg == SPA_FOL_OK && cfg_follow && fol_expire) |=> (fol_reg == SPA_FOL_TIMEOUT && !drive_enable_o))
        else $error("follower did not time out at 100 ms");
    a_orange_solid: assert property (
        (ce_i && fol_next == SPA_FOL_TIMEOUT && robot_enable_i && !red_active && !can_error_frame_i)
        |=> (led_o == SPA_LED_SOLID_ORANGE))
        else $error("timed out follower not shown solid orange");
    a_sticky_keeps: assert property (
        (ce_i && |fault_i) |=> ((sticky_reg & $past(fault_i)) == $past(fault_i)))
        else $error("live fault lost from sticky log");
    a_sticky_clear: assert property (
        (ce_i && wr_fault && fault_i == 8'h00) |=> (sticky_reg == 8'h00))
        else $error("sticky clear had no effect");
    a_brake_override: assert property (
        (ce_i && cfg_ovr_valid) |=> (brake_o == $past(cfg_ovr_brake)))
        else $error("brake override ignored");
    a_red_flash: assert property (
        (ce_i && can_error_frame_i) |=> (led_o == SPA_LED_RED && red_active))
        else $error("error frame did not flash red");
    a_report_strobe: assert property (
        (ce_i && rep_due) |=> (report_strobe_o && rep_pos_reg == $past(sel_pos)))
        else $error("position report missed");
    a_raw_strobe: assert property (
        (ce_i && raw_due) |=> (raw_strobe_o && raw_ana_reg == $past(analog_i)))
        else $error("raw report missed");

    c_index_clear: cover property (ce_i && clr_idx ##1 quad_pos_reg == 32'h0);
    c_follow_timeout: cover property (fol_reg == SPA_FOL_OK ##1 fol_reg == SPA_FOL_TIMEOUT);
    c_sticky_clear: cover property (sticky_reg != 8'h00 ##1 wr_fault ##1 sticky_reg == 8'h00);
    c_red_flash: cover property (led_o == SPA_LED_RED);

endmodule

// File: verif/spa_robot_model.sv
// Purpose: robot controller model sending periodic control frames
// Assumes: each control frame reaches the block as a one-cycle update pulse
// Notes: PERIOD in clk_i cycles; 10 ms at the scaled tick by default
`timescale 1ns/100ps
module spa_robot_model #(
    parameter int unsigned PERIOD = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic update_o
);
    int unsigned cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_reg <= 0;
            update_o <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
            update_o <= (cnt_reg == PERIOD - 1);
        end
    end
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for the position auto-clear block
// Assumes: TICK_LEN of 10 cycles per ms, one ack per access
// Notes: positions are seen only through the 20 ms snapshot and raw encoder snapshot registers
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top
    import spa_pkg::*;
;
    localparam int TK = 10;
    logic clk_i, rst_i, idx_drv, idx_lvl, fwd, rev, stp, dir, rob_en, upd, can_err, btn, run;
    logic [9:0] ana;
    logic [7:0] flt;
    spa_wb_req_t wb;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, drive_enable_o, brake_o, report_strobe_o, raw_strobe_o;
    spa_led_t led_o;
    int fails = 0;
    int checks_done = 0;
    int n;

    spa_autoclear #(.TICK_LEN(TK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .index_drive_i(idx_drv), .index_level_i(idx_lvl),
        .fwd_limit_closed_i(fwd), .rev_limit_closed_i(rev), .enc_step_i(stp), .enc_dir_i(dir),
        .analog_i(ana), .fault_i(flt), .robot_enable_i(rob_en), .master_update_i(upd),
        .can_error_frame_i(can_err), .cal_button_i(btn), .drive_enable_o(drive_enable_o),
        .brake_o(brake_o), .led_o(led_o), .report_strobe_o(report_strobe_o), .raw_strobe_o(raw_strobe_o));

    spa_robot_model #(.PERIOD(10 * TK)) u_robot (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .update_o(upd));

    // ----------------------------------------
    // bus and pin tasks
    // ----------------------------------------
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb <= '0;
    endtask

    task automatic steps(input int k);
        repeat (k) begin
            @(posedge clk_i);
            stp <= 1'b1;
            @(posedge clk_i);
            stp <= 1'b0;
        end
    endtask

    // pull selects the open-drain release instead of a driven high
    task automatic idx_pulse(input logic pull);
        @(posedge clk_i);
        idx_drv <= 1'b1;
        idx_lvl <= 1'b0;
        repeat (4) @(posedge clk_i);
        if (pull) idx_drv <= 1'b0;
        else idx_lvl <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic pos_is(input logic [31:0] e);
        // skip a snapshot launched before the last stimulus has settled
        repeat (2) @(posedge clk_i);
        do @(posedge clk_i); while (report_strobe_o !== 1'b1);
        acc(1'b0, OFS_POS, 32'h0);
    endtask

    task automatic per(input logic raw);
        do @(posedge clk_i); while ((raw ? raw_strobe_o : report_strobe_o) !== 1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((raw ? raw_strobe_o : report_strobe_o) !== 1'b1);
    endtask

    task automatic finish_test;
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // tests need about 6k cycles; 50k leaves ample margin
    initial begin
        #500000;
        fails++;
        finish_test;
    end

    initial begin
        wb = '0; idx_drv = 1'b1; idx_lvl = 1'b0; fwd = 1'b0; rev = 1'b0; stp = 1'b0; dir = 1'b0;
        ana = 10'h0; flt = 8'h0; rob_en = 1'b0; can_err = 1'b0; btn = 1'b0; run = 1'b0; rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(1'b0, OFS_CTRL, 32'h0); `CHK(q, 32'h0)
        acc(1'b0, OFS_RAW_RATE, 32'h0); `CHK(q, {24'h0, RAW_RATE_RESET})
        acc(1'b0, OFS_DEV_ID, 32'h0); `CHK(q, {26'h0, DEV_ID_RESET})
        acc(1'b1, OFS_DEV_ID, 32'h3f);
        acc(1'b1, OFS_DEV_ID, 32'h0);
        acc(1'b0, OFS_DEV_ID, 32'h0); `CHK(q, 32'h3f)
        acc(1'b0, 8'h80, 32'h0); `CHK(q, 32'h0)
        // drive stays disabled through the clearing tests
        acc(1'b1, OFS_CTRL, 32'h1);
        steps(5);
        pos_is(0); `CHK(q, 32'h5)
        idx_pulse(1'b0);
        pos_is(0); `CHK(q, 32'h0)
        steps(3);
        idx_pulse(1'b1);
        pos_is(0); `CHK(q, 32'h0)
        acc(1'b1, OFS_CTRL, 32'h0);
        steps(2);
        idx_pulse(1'b0);
        pos_is(0); `CHK(q, 32'h2)
        acc(1'b1, OFS_CTRL, 32'h2);
        fwd <= 1'b1;
        steps(4);
        pos_is(0); `CHK(q, 32'h0)
        fwd <= 1'b0;
        // limit synchroniser still reads closed for two edges
        repeat (3) @(posedge clk_i);
        steps(1);
        rev <= 1'b1;
        steps(1);
        pos_is(0); `CHK(q, 32'h2)
        acc(1'b1, OFS_CTRL, 32'h4);
        pos_is(0); `CHK(q, 32'h0)
        rev <= 1'b0;
        acc(1'b1, OFS_CTRL, 32'h9);
        ana <= 10'h12c;
        idx_pulse(1'b0);
        ana <= 10'h136;
        pos_is(0); `CHK(q, 32'ha)
        acc(1'b1, OFS_CTRL, 32'h19);
        pos_is(0); `CHK(q, 32'hfffffff6)
        acc(1'b0, OFS_VEL, 32'h0); `CHK(q, 32'hffffffec)
        per(1'b0); `CHK(n, 20 * TK)
        per(1'b1); `CHK(n, 100 * TK)
        acc(1'b1, OFS_RAW_RATE, 32'h5);
        steps(3);
        per(1'b1);
        per(1'b1); `CHK(n, 5 * TK)
        acc(1'b0, OFS_RAW_ENC, 32'h0); `CHK(q, 32'h3)
        acc(1'b0, OFS_RAW_ANA, 32'h0); `CHK(q, 32'h136)
        flt <= 8'h05;
        repeat (2) @(posedge clk_i);
        flt <= 8'h00;
        acc(1'b0, OFS_FAULT, 32'h0); `CHK(q, 32'h500)
        acc(1'b1, OFS_FAULT, 32'h0);
        acc(1'b0, OFS_FAULT, 32'h0); `CHK(q, 32'h0)
        rob_en <= 1'b1;
        run <= 1'b1;
        acc(1'b1, OFS_CTRL, 32'h20);
        flt <= 8'hff;
        repeat (50) @(posedge clk_i);
        `CHK(drive_enable_o, 1'b1)
        flt <= 8'h00;
        // stop right after a frame so the silent span is known
        do @(posedge clk_i); while (upd !== 1'b1);
        run <= 1'b0;
        repeat (95 * TK) @(posedge clk_i);
        `CHK(drive_enable_o, 1'b1)
        repeat (10 * TK) @(posedge clk_i);
        `CHK(drive_enable_o, 1'b0)
        `CHK(led_o, SPA_LED_SOLID_ORANGE)
        acc(1'b0, OFS_STATUS, 32'h0); `CHK(q, 32'h28)
        run <= 1'b1;
        do @(posedge clk_i); while (upd !== 1'b1);
        repeat (3) @(posedge clk_i);
        `CHK(drive_enable_o, 1'b1)
        can_err <= 1'b1;
        @(posedge clk_i);
        can_err <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(led_o, SPA_LED_RED)
        repeat (60 * TK) @(posedge clk_i);
        `CHK(led_o, SPA_LED_OFF)
        btn <= 1'b1;
        repeat (4) @(posedge clk_i);
        btn <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(brake_o, 1'b1)
        acc(1'b1, OFS_CTRL, 32'h60);
        repeat (3) @(posedge clk_i);
        `CHK(brake_o, 1'b0)
        btn <= 1'b1;
        repeat (4) @(posedge clk_i);
        btn <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(brake_o, 1'b0)
        // override off: the press under override must have toggled the stored mode
        acc(1'b1, OFS_CTRL, 32'h20);
        repeat (3) @(posedge clk_i);
        `CHK(brake_o, 1'b0)
        finish_test;
    end
endmodule
